// ==== verilog/serial_bus_controller.v ====
// Contract
// - bit rate up to system clock over twenty
// - software exchanges whole bytes, hardware shifts bits
// - master, slave or both, multi-master safe
// - one data register for data and addresses
// - lines driven only open-drain, idle high
// - master starts transfers and supplies clock
// - START plus address makes sender the master
// - START, address with direction, data, STOP
// - receiver acks by SDA low during SCL high
// - direction one reads, zero writes
// - transmitter waits for receiver ack per byte
// - master ends transfer with STOP
// - master starts only on a free bus
// - high sent but low seen loses arbitration
// - arbitration loser continues as slave
// - master waits while SCL held low
// - SCL low past 25 ms is timeout
// - low timeout timer reloads high, counts low
// - free after ten bit-clock periods both high
// - pending START issued on free timeout
// - free timeout needs running bit clock
// - clock-low extension supported
// - one overflow sets minimum low and high
// - interrupt after ack on send, before on receive
// - free timeout acts like detected STOP
// - inhibited slave nacks addresses, no events; data bytes after the nacked address still raise events here
`timescale 1ns/100ps
`include "serial_bus_regs.vh"
module serial_bus_controller #(
  parameter LOW_TIMEOUT_CYCLES = 1250000,
  parameter RELEASE_CYCLES     = 500000
) (
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_reset,
  // bit clock sources (timer overflow pulses)
  input  wire [3:0] i_overflow,
  // configuration
  input  wire [7:0] i_cfg,
  // control writes: set start, stop, ack value, clear event
  input  wire       i_ctl_wr,
  input  wire [7:0] i_ctl_wdata,
  // data register write strobe and write data
  input  wire       i_data_wr,
  input  wire [7:0] i_data_wdata,
  // byte side buffer drain
  input  wire       i_rx_ready,
  // serial lines
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_scl_oe,
  output reg        o_sda_oe,
  output reg        o_scl_out,
  output reg        o_sda_out,
  // status
  output reg  [7:0] o_status,
  output reg        o_busy,
  output reg  [7:0] o_data,
  output reg        o_rx_valid,
  output reg  [7:0] o_rx_data,
  output reg        o_low_timeout
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  reg [1:0] scl_s;
  reg [1:0] sda_s;
  reg       scl_q;
  reg       sda_q;
  always @(posedge i_core_clk) begin
    scl_s <= {scl_s[0], i_scl};
    sda_s <= {sda_s[0], i_sda};
    scl_q <= scl_s[1];
    sda_q <= sda_s[1];
  end
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire start_seen = scl & scl_q & sda_q & ~sda;
  wire stop_seen  = scl & scl_q & ~sda_q & sda;
  wire enable   = i_cfg[`CFG_ENABLE];
  wire tick     = i_overflow[{i_cfg[`CFG_CS_HI], i_cfg[`CFG_CS_LO]}];
  wire [3:0] hold_cyc = i_cfg[`CFG_EXTHOLD] ? `HOLD_LONG : `HOLD_SHORT;

  // ---------------------------------------------------------------
  // low timeout and free timeout
  // ---------------------------------------------------------------
  reg [31:0] low_cnt;
  reg [3:0]  free_cnt;
  wire       free_to = i_cfg[`CFG_FREE_TO_EN] & o_busy & scl & sda & tick
                       & (free_cnt == `FREE_PERIODS);
  always @(posedge i_core_clk) begin
    if (i_reset | ~enable | ~i_cfg[`CFG_LOW_TO_EN] | scl) begin
      low_cnt <= 32'h0;
    end else if (low_cnt != LOW_TIMEOUT_CYCLES) begin
      low_cnt <= low_cnt + 32'h1;
    end
    if (i_reset | ~enable | ~(scl & sda)) begin
      free_cnt <= 4'h0;
    end else if (tick && free_cnt != `FREE_PERIODS) begin
      free_cnt <= free_cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_LOW   = 3'h2;
  localparam ST_HIGH  = 3'h3;
  localparam ST_WAIT  = 3'h4;
  localparam ST_STOP  = 3'h5;
  localparam ST_SLAVE = 3'h6;

  reg [2:0]  state;
  reg [3:0]  bitn;
  reg [7:0]  shreg;
  reg [7:0]  ctl;
  reg        addr_phase;
  reg        inhibit_now;
  reg        phase_ticks;
  reg [3:0]  hold_cnt;
  reg        start_req;
  reg        sda_next;
  reg [31:0] release_cnt;
  // two-entry receive buffer
  reg [7:0]  buf_mem [0:1];
  reg [1:0]  buf_cnt;
  reg        buf_wp;
  reg        buf_rp;
  wire       buf_full = (buf_cnt == 2'h2);
  reg        rx_push;
  reg [7:0]  rx_byte;
  wire       sending = ctl[`CTL_TXMODE];
  wire       is_master = ctl[`CTL_MASTER];

  always @(posedge i_core_clk) begin
    rx_push <= 1'b0;
    if (i_reset | ~enable) begin
      state       <= ST_IDLE;
      ctl         <= `CTL_RESET;
      bitn        <= 4'h0;
      shreg       <= `DATA_RESET;
      o_data      <= `DATA_RESET;
      o_scl_oe    <= 1'b0;
      o_sda_oe    <= 1'b0;
      o_sda_out   <= 1'b0;
      o_busy      <= 1'b0;
      addr_phase  <= 1'b0;
      inhibit_now <= 1'b0;
      phase_ticks <= 1'b0;
      hold_cnt    <= 4'h0;
      start_req   <= 1'b0;
      release_cnt <= 32'h0;
      rx_byte     <= 8'h00;
      o_low_timeout <= 1'b0;
    end else begin
      if (low_cnt == LOW_TIMEOUT_CYCLES) begin
        o_low_timeout <= 1'b1;
      end
      if (o_low_timeout) begin
        release_cnt <= release_cnt + 32'h1;
        if (release_cnt == RELEASE_CYCLES) begin
          state <= ST_IDLE;
          o_scl_oe <= 1'b0;
          o_sda_oe <= 1'b0;
          o_low_timeout <= 1'b0;
          release_cnt <= 32'h0;
        end
      end
      // software writes; event flag set by hardware wins over clear
      if (i_ctl_wr) begin
        ctl[`CTL_ACK] <= i_ctl_wdata[`CTL_ACK];
        if (i_ctl_wdata[`CTL_START]) start_req <= 1'b1;
        ctl[`CTL_STOP] <= i_ctl_wdata[`CTL_STOP];
        if (!i_ctl_wdata[`CTL_SI]) ctl[`CTL_SI] <= 1'b0;
        if (!i_ctl_wdata[`CTL_ARBLOST]) ctl[`CTL_ARBLOST] <= 1'b0;
      end
      if (i_data_wr) begin
        o_data <= i_data_wdata;
      end
      if (start_seen) begin
        o_busy <= 1'b1;
      end
      if (stop_seen | free_to) begin
        o_busy <= 1'b0;
        if (!is_master && state == ST_SLAVE && !inhibit_now) begin
          ctl[`CTL_STOP] <= 1'b1;
          ctl[`CTL_SI]   <= 1'b1;
        end
      end
      case (state)
        ST_IDLE: begin
          if (start_req && scl && sda && (!o_busy || free_to)) begin
            o_sda_oe   <= 1'b1;
            o_sda_out  <= 1'b0;
            phase_ticks <= 1'b0;
            start_req  <= 1'b0;
            o_busy     <= 1'b1;
            state      <= ST_START;
          end else if (start_seen) begin
            inhibit_now <= i_cfg[`CFG_INHIBIT];
            addr_phase  <= 1'b1;
            bitn        <= 4'h0;
            ctl[`CTL_TXMODE] <= 1'b0;
            state       <= ST_SLAVE;
          end
        end
        ST_START: begin
          if (tick) begin
            o_scl_oe <= 1'b1;
            ctl[`CTL_MASTER] <= 1'b1;
            ctl[`CTL_TXMODE] <= 1'b1;
            ctl[`CTL_START]  <= 1'b1;
            ctl[`CTL_SI]     <= 1'b1; // start event
            addr_phase <= 1'b1;
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (i_ctl_wr && !i_ctl_wdata[`CTL_SI]) begin
            ctl[`CTL_START] <= 1'b0;
            if (ctl[`CTL_ACKRQ]) begin
              o_sda_oe <= i_ctl_wdata[`CTL_ACK];
              sda_next <= i_ctl_wdata[`CTL_ACK];
              bitn <= `BIT_ACK;
              ctl[`CTL_ACKRQ] <= 1'b0;
              state <= is_master ? ST_LOW : ST_SLAVE;
            end else if (is_master && i_ctl_wdata[`CTL_STOP]) begin
              o_sda_oe <= 1'b1;
              state <= ST_STOP;
            end else begin
              shreg <= i_data_wr ? i_data_wdata : o_data;
              bitn  <= 4'h0;
              o_sda_oe <= sending & ~(i_data_wr ? i_data_wdata[7] : o_data[7]);
              sda_next <= sending & ~(i_data_wr ? i_data_wdata[7] : o_data[7]);
              state <= is_master ? ST_LOW : ST_SLAVE;
            end
            hold_cnt <= 4'h0;
            phase_ticks <= 1'b0;
          end
        end
        ST_LOW: begin
          if (hold_cnt != hold_cyc) hold_cnt <= hold_cnt + 4'h1;
          if (hold_cnt == hold_cyc - 4'h1) o_sda_oe <= sda_next;
          if (tick && hold_cnt == hold_cyc) begin
            o_scl_oe <= 1'b0;
            phase_ticks <= 1'b0;
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          // clock stays low while another party stretches it
          if (scl) begin
            if (scl_rise) begin
              if (o_sda_oe == 1'b0 && !sda && sending && bitn <= `BIT_LAST) begin
                ctl[`CTL_ARBLOST] <= 1'b1;
                ctl[`CTL_MASTER]  <= 1'b0;
                ctl[`CTL_TXMODE]  <= 1'b0;
                state <= ST_SLAVE;
              end
              shreg <= {shreg[6:0], sda};
            end
            if (tick) phase_ticks <= 1'b1;
            if (tick && phase_ticks) begin
              o_scl_oe <= 1'b1;
              hold_cnt <= 4'h0;
              if (bitn == `BIT_ACK && !sending) begin
                bitn <= 4'h0;
                sda_next <= 1'b0;
                state <= ctl[`CTL_STOP] ? ST_STOP : ST_LOW;
              end else if (bitn == `BIT_ACK) begin
                o_sda_oe <= 1'b0;
                if (sending) ctl[`CTL_ACK] <= ~sda;
                ctl[`CTL_SI] <= 1'b1;
                addr_phase <= 1'b0;
                if (addr_phase) ctl[`CTL_TXMODE] <= ~o_data[0];
                state <= ST_WAIT;
              end else if (bitn == `BIT_LAST) begin
                bitn <= `BIT_ACK;
                if (sending) begin
                  sda_next <= 1'b0;
                  state <= ST_LOW;
                end else begin
                  o_data <= shreg;
                  rx_byte <= shreg;
                  rx_push <= 1'b1;
                  ctl[`CTL_ACKRQ] <= 1'b1;
                  ctl[`CTL_SI] <= 1'b1;
                  state <= ST_WAIT;
                end
              end else begin
                bitn <= bitn + 4'h1;
                sda_next <= sending & ~shreg[7];
                state <= ST_LOW;
              end
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            if (o_scl_oe && !o_sda_oe) begin
              o_sda_oe <= 1'b1;
            end else if (o_scl_oe) begin
              o_scl_oe <= 1'b0;
            end else if (scl) begin
              o_sda_oe <= 1'b0;
              ctl[`CTL_MASTER] <= 1'b0;
              ctl[`CTL_STOP] <= 1'b0;
              state <= ST_IDLE;
            end
          end
        end
        ST_SLAVE: begin
          if (stop_seen | free_to) begin
            o_sda_oe <= 1'b0;
            state <= ST_IDLE;
          end else if (start_seen) begin
            addr_phase <= 1'b1;
            inhibit_now <= i_cfg[`CFG_INHIBIT];
            bitn <= 4'h0;
          end else if (scl_rise) begin
            if (bitn <= `BIT_LAST) shreg <= {shreg[6:0], sda};
            else if (sending) ctl[`CTL_ACK] <= ~sda;
          end else if (scl_fall) begin
            hold_cnt <= 4'h0;
            if (bitn == `BIT_LAST) begin
              bitn <= `BIT_ACK;
              if (sending) begin
                o_sda_oe <= 1'b0;
              end else if (inhibit_now && addr_phase) begin
                o_sda_oe <= 1'b0;
              end else begin
                o_data <= shreg;
                rx_byte <= shreg;
                rx_push <= 1'b1;
                ctl[`CTL_ACKRQ] <= 1'b1;
                ctl[`CTL_SI] <= 1'b1;
                o_scl_oe <= 1'b1;
                if (addr_phase) ctl[`CTL_TXMODE] <= shreg[0];
                state <= ST_WAIT;
              end
            end else if (bitn == `BIT_ACK) begin
              o_sda_oe <= 1'b0;
              bitn <= 4'h0;
              addr_phase <= 1'b0;
              if (sending && !inhibit_now) begin
                ctl[`CTL_SI] <= 1'b1;
                o_scl_oe <= 1'b1;
                state <= ST_WAIT;
              end
            end else begin
              bitn <= bitn + 4'h1;
              o_sda_oe <= sending & ~shreg[7];
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (state == ST_WAIT && !is_master && i_ctl_wr && !i_ctl_wdata[`CTL_SI]) begin
        o_scl_oe <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // receive buffer and status
  // ---------------------------------------------------------------
  wire pop  = o_rx_valid & i_rx_ready;
  wire push = rx_push & ~buf_full;
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      buf_cnt    <= 2'h0;
      buf_wp     <= 1'b0;
      buf_rp     <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
      o_status   <= `CTL_RESET;
      o_scl_out  <= 1'b0;
    end else begin
      o_scl_out <= 1'b0;
      o_status  <= ctl;
      if (push) begin
        buf_mem[buf_wp] <= rx_byte;
        buf_wp <= ~buf_wp;
      end
      if (pop) buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
      o_rx_valid <= (buf_cnt + {1'b0, push} - {1'b0, pop}) != 2'h0;
      o_rx_data  <= (push & ((buf_cnt == 2'h0) | ((buf_cnt == 2'h1) & pop))) ? rx_byte
                    : buf_mem[pop ? ~buf_rp : buf_rp];
    end
  end
endmodule

// ==== verilog/serial_bus_regs.vh ====
`ifndef SERIAL_BUS_REGS_VH
`define SERIAL_BUS_REGS_VH
// configuration register fields
`define CFG_ENABLE        7
`define CFG_INHIBIT       6
`define CFG_BUSY          5
`define CFG_EXTHOLD       4
`define CFG_LOW_TO_EN     3
`define CFG_FREE_TO_EN    2
`define CFG_CS_HI         1
`define CFG_CS_LO         0
`define CFG_RESET         8'h00
// control/status register fields
`define CTL_MASTER        7
`define CTL_TXMODE        6
`define CTL_START         5
`define CTL_STOP          4
`define CTL_ACKRQ         3
`define CTL_ARBLOST       2
`define CTL_ACK           1
`define CTL_SI            0
`define CTL_RESET         8'h00
`define DATA_RESET        8'h00
// timing
`define FREE_PERIODS      4'hA
`define MIN_BIT_DIV       5'h14
`define HOLD_SHORT        4'h3
`define HOLD_LONG         4'hC
`define BIT_LAST          4'h7
`define BIT_ACK           4'h8
`endif

// ==== bench/serial_bus_controller_assertions.sv ====
`timescale 1ns/100ps
module serial_bus_controller_assertions #(
  parameter LOW_TIMEOUT_CYCLES = 1250000,
  parameter RELEASE_CYCLES     = 500000
) (
  input wire       i_core_clk,
  input wire       i_reset,
  input wire [7:0] i_cfg,
  input wire       i_ctl_wr,
  input wire [7:0] i_ctl_wdata,
  input wire       i_rx_ready,
  input wire       i_scl,
  input wire       o_scl_oe,
  input wire       o_sda_oe,
  input wire       o_scl_out,
  input wire       o_sda_out,
  input wire [7:0] o_status,
  input wire       o_busy,
  input wire       o_rx_valid,
  input wire [7:0] o_rx_data,
  input wire       o_low_timeout
);
  integer low_cnt;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // --------------------------------
  // scl low length seen at the pin
  // --------------------------------
  always @(posedge i_core_clk)
    if (i_reset || i_scl) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  scl_open_drain_a: assert property (o_scl_oe |-> !o_scl_out)
    else $error("scl driven high");
  sda_open_drain_a: assert property (o_sda_oe |-> !o_sda_out)
    else $error("sda driven high");
  disable_release_a: assert property (!i_cfg[7] [*3] |-> !o_scl_oe && !o_sda_oe)
    else $error("lines held while disabled");
  start_drive_a: assert property (
    i_ctl_wr && i_ctl_wdata[5] && i_cfg[7] && !o_busy && !o_status[7] |-> ##[1:200] o_sda_oe)
    else $error("start not driven");
  scl_low_min_a: assert property ($rose(o_scl_oe) |-> o_scl_oe [*4])
    else $error("scl low too short");
  rx_hold_a: assert property (
    o_rx_valid && !i_rx_ready && i_cfg[7] |=> o_rx_valid && $stable(o_rx_data))
    else $error("buffered byte lost");
  event_stands_a: assert property (
    o_status[0] && !i_ctl_wr && !$past(i_ctl_wr) && i_cfg[7] |=> o_status[0])
    else $error("event flag dropped");
  timeout_count_a: assert property (
    $rose(o_low_timeout) |-> low_cnt >= LOW_TIMEOUT_CYCLES - 4)
    else $error("low timeout early");
  timeout_release_a: assert property (
    $rose(o_low_timeout) |-> ##[1:80] (!o_scl_oe && !o_sda_oe))
    else $error("lines not released");
endmodule

// ==== bench/smbus_slave_model.sv ====
`timescale 1ns/100ps
module smbus_slave_model #(
  parameter [6:0] ADDR = 7'h2A
) (
  input  wire        i_scl,
  input  wire        i_sda,
  input  wire [15:0] i_stretch_ns,
  input  wire [7:0]  i_rd_byte,
  output reg         o_scl_low,
  output reg         o_sda_low,
  output reg  [7:0]  o_last_rx
);
  integer   bitn;
  reg       sel;
  reg       rd;
  reg       first;
  reg       nak;
  reg [7:0] tx;
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    bitn = 9;
    sel = 1'b0;
  end
  // -------------------------------
  // framing seen with scl high
  // -------------------------------
  always @(negedge i_sda)
    if (i_scl) begin
      bitn = -1;
      first = 1'b1;
      sel = 1'b0;
    end
  always @(posedge i_sda)
    if (i_scl)
      sel = 1'b0;
  always @(posedge i_scl)
    if (bitn == 8)
      nak = i_sda;
    else if (bitn >= 0 && bitn < 8)
      o_last_rx = {o_last_rx[6:0], i_sda};
  // responds only to the master's clock
  always @(negedge i_scl) begin
    bitn = bitn + 1;
    o_sda_low = 1'b0;
    if (bitn == 8) begin
      if (first) begin
        sel = o_last_rx[7:1] == ADDR;
        rd = o_last_rx[0];
      end
      o_sda_low = sel && (first || !rd);
      first = 1'b0;
    end else if (bitn == 9) begin
      bitn = 0;
      tx = i_rd_byte;
      if (nak && rd)
        sel = 1'b0;
      if (i_stretch_ns != 16'h0000) begin
        o_scl_low = 1'b1;
        o_scl_low <= #(i_stretch_ns) 1'b0;
      end
    end
    if (sel && rd && !first && bitn < 8) begin
      o_sda_low = !tx[7];
      tx = tx << 1;
    end
  end
endmodule

// ==== bench/smbus_master_slave_controller_tb.sv ====
`timescale 1ns/100ps
module smbus_master_slave_controller_tb;
  reg         i_core_clk;
  reg         i_reset;
  reg  [3:0]  i_overflow;
  reg  [7:0]  i_cfg;
  reg         i_ctl_wr;
  reg  [7:0]  i_ctl_wdata;
  reg         i_data_wr;
  reg  [7:0]  i_data_wdata;
  reg         i_rx_ready;
  reg  [7:0]  slv_rd;
  reg  [15:0] stretch_ns;
  reg  [3:0]  ovf;
  wire        o_scl_oe, o_sda_oe, o_scl_out, o_sda_out, o_busy, o_rx_valid, o_low_timeout;
  wire [7:0]  o_status, o_data, o_rx_data, slv_rx;
  wire        slv_scl_low, slv_sda_low;
  integer     n_fail, total_checks, cyc, i, k;
  wire        scl = !(o_scl_oe || slv_scl_low);
  wire        sda = !(o_sda_oe || slv_sda_low);
  serial_bus_controller #(.LOW_TIMEOUT_CYCLES(200), .RELEASE_CYCLES(50)) dut (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_overflow(i_overflow), .i_cfg(i_cfg),
    .i_ctl_wr(i_ctl_wr), .i_ctl_wdata(i_ctl_wdata), .i_data_wr(i_data_wr),
    .i_data_wdata(i_data_wdata), .i_rx_ready(i_rx_ready), .i_scl(scl), .i_sda(sda),
    .o_scl_oe(o_scl_oe), .o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out), .o_sda_out(o_sda_out),
    .o_status(o_status), .o_busy(o_busy), .o_data(o_data), .o_rx_valid(o_rx_valid),
    .o_rx_data(o_rx_data), .o_low_timeout(o_low_timeout));
  smbus_slave_model #(.ADDR(7'h2A)) slv (
    .i_scl(scl), .i_sda(sda), .i_stretch_ns(stretch_ns), .i_rd_byte(slv_rd),
    .o_scl_low(slv_scl_low), .o_sda_low(slv_sda_low), .o_last_rx(slv_rx));
  initial begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  // --------------------------------
  // bit clock ticks and watchdog
  // --------------------------------
  always @(posedge i_core_clk) begin
    ovf <= (ovf == 4'h9) ? 4'h0 : ovf + 4'h1;
    i_overflow <= {4{ovf == 4'h0}};
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  task chk(input string name, input [7:0] exp, input [7:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %s exp %h got %h", name, exp, got);
      end
    end
  endtask
  task ctl(input [7:0] v);
    begin
      @(posedge i_core_clk);
      i_ctl_wr <= 1'b1;
      i_ctl_wdata <= v;
      @(posedge i_core_clk);
      i_ctl_wr <= 1'b0;
    end
  endtask
  function [7:0] probe(input integer sel);
    probe = sel == 0 ? {7'h00, o_status[0]} : sel == 1 ? {7'h00, o_busy} : {7'h00, o_low_timeout};
  endfunction
  task wait_on(input integer sel, input [7:0] exp, input string name);
    begin
      k = 0;
      repeat (2) @(posedge i_core_clk);
      #1;
      while (probe(sel) !== exp && k < 2000) begin
        @(posedge i_core_clk);
        #1;
        k = k + 1;
      end
      chk(name, exp, probe(sel));
    end
  endtask
  // start, address byte, then clear the event to shift it
  task start_addr(input [7:0] a);
    begin
      ctl(8'h20);
      wait_on(0, 8'h01, "start_ev");
      chk("master", 8'h80, o_status & 8'h80);
      @(posedge i_core_clk);
      i_data_wr <= 1'b1;
      i_data_wdata <= a;
      @(posedge i_core_clk);
      i_data_wr <= 1'b0;
      ctl(8'h00);
      wait_on(0, 8'h01, "addr_ev");
      chk("ack", 8'h02, o_status & 8'h02);
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    n_fail = 0;
    total_checks = 0;
    cyc = 0;
    ovf = 4'h0;
    stretch_ns = 16'h0000;
    slv_rd = 8'h3C;
    i_reset = 1'b1;
    i_overflow = 4'h0;
    i_cfg = 8'h00;
    i_ctl_wr = 1'b0;
    i_ctl_wdata = 8'h00;
    i_data_wr = 1'b0;
    i_data_wdata = 8'h00;
    i_rx_ready = 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_reset <= 1'b0;
    i_cfg <= 8'h8C;
    #1;
    chk("status", 8'h00, o_status);
    chk("data", 8'h00, o_data);
    start_addr(8'h54);
    @(posedge i_core_clk);
    i_data_wr <= 1'b1;
    i_data_wdata <= 8'hA5;
    @(posedge i_core_clk);
    i_data_wr <= 1'b0;
    ctl(8'h00);
    @(posedge i_core_clk);
    #1;
    chk("event_clr", 8'h00, o_status & 8'h01);
    wait_on(0, 8'h01, "data_ev");
    chk("ack", 8'h02, o_status & 8'h02);
    chk("slave_rx", 8'hA5, slv_rx);
    ctl(8'h10);
    wait_on(1, 8'h00, "idle");
    stretch_ns = 16'd400;
    start_addr(8'h55);
    ctl(8'h02);
    for (i = 0; i < 3; i = i + 1) begin
      wait_on(0, 8'h01, "rx_ev");
      chk("rx_byte", 8'h3C + i[7:0], o_data);
      slv_rd <= 8'h3D + i[7:0];
      ctl(i == 2 ? 8'h10 : 8'h02);
    end
    wait_on(1, 8'h00, "idle");
    for (i = 0; i < 2; i = i + 1) begin
      chk("rx_valid", 8'h01, {7'h00, o_rx_valid});
      chk("rx_data", 8'h3C + i[7:0], o_rx_data);
      @(posedge i_core_clk);
      i_rx_ready <= 1'b1;
      @(posedge i_core_clk);
      i_rx_ready <= 1'b0;
      #1;
    end
    chk("rx_valid", 8'h00, {7'h00, o_rx_valid});
    stretch_ns = 16'd6000;
    start_addr(8'h54);
    wait_on(2, 8'h01, "low_to");
    repeat (80) @(posedge i_core_clk);
    #1;
    chk("oe", 8'h00, {6'h00, o_scl_oe, o_sda_oe});
    @(posedge i_core_clk);
    i_cfg <= 8'h00;
    repeat (4) @(posedge i_core_clk);
    i_cfg <= 8'h8C;
    stretch_ns = 16'h0000;
    wait_on(1, 8'h00, "free");
    start_addr(8'h54);
    ctl(8'h10);
    wait_on(1, 8'h00, "idle");
    conclude;
  end
endmodule
bind serial_bus_controller serial_bus_controller_assertions #(
  .LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES), .RELEASE_CYCLES(RELEASE_CYCLES)) chk_u (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_cfg(i_cfg), .i_ctl_wr(i_ctl_wr),
  .i_ctl_wdata(i_ctl_wdata), .i_rx_ready(i_rx_ready), .i_scl(i_scl), .o_scl_oe(o_scl_oe),
  .o_sda_oe(o_sda_oe), .o_scl_out(o_scl_out), .o_sda_out(o_sda_out), .o_status(o_status),
  .o_busy(o_busy), .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
  .o_low_timeout(o_low_timeout));
